/* core/process_pid_regulator.sv */
// process regulator: apb registers, source select, shared divider, pid math
// assumes analog, pulse and comm values come from logic on pclk, the two
// digital inputs come from pins
//
// Summary of operation
// - setpoint source selector, codes 0 to 6
// - relative values 0-100 %, setpoint default 50 %
// - feedback source selector, codes 0 to 8
// - direction bit flips deviation sign
// - input function 35 inverts direction
// - monitors scale 100 % to display range
// - proportional term, gain 1000 gives full
// - integral reaches full after integral time
// - derivative on feedback change, zero disables
// - reverse output limited to cutoff
// - deadband holds present output
// - derivative term clamped to limit
// - setpoint ramps linearly over ramp time
// - feedback and output low-pass filters
// - second gain set behaves like first
// - gain switchover mode codes 0 to 3
// - input function 43 selects gain set
// - deviation mode interpolates between thresholds
// - low threshold at most high threshold
// - new output every 2 ms
module process_pid_regulator
  import pid_pkg::*;
#(
  parameter int CALC_CYCLES_P = CALC_CYCLES
) (
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [APB_ADDR_W-1:0] paddr,
  input  wire logic [31:0]           pwdata,
  output logic      [31:0]           prdata,
  output logic                       pready,
  output logic                       pslverr,
  input  wire logic signed [15:0]    analog_in_a,
  input  wire logic signed [15:0]    analog_in_b,
  input  wire logic signed [15:0]    analog_in_c,
  input  wire logic signed [15:0]    fast_pulse_input,
  input  wire logic signed [15:0]    comm_value,
  input  wire logic signed [15:0]    multi_ref_value,
  input  wire logic                  dir_invert_pin,
  input  wire logic                  gain_set_pin,
  output pct_type                    freq_ref,
  output logic      [31:0]           setpoint_monitor,
  output logic      [31:0]           feedback_monitor
);

  localparam int TICK_W = $clog2(CALC_CYCLES_P + 1);

  typedef struct packed {
    logic [NRW-1:0][31:0] cfg;
    logic [31:0]          prdata;
    logic                 pready;
    logic                 pslverr;
    logic [1:0]           inv_s;
    logic [1:0]           gsel_s;
    logic [TICK_W-1:0]    tick;
    phase_type            phase;
    logic                 busy;
    logic [5:0]           cnt;
    logic [DIV_W-1:0]     dn;
    logic [32:0]          dr;
    logic [31:0]          dd;
    logic                 dneg;
    pct_type              sp;
    pct_type              fbf;
    pct_type              fbp;
    pct_type              integ;
    pct_type              pterm;
    pct_type              outu;
    pct_type              outf;
    pct_type              frq;
    pct_type              spm;
    pct_type              fbm;
    pct_type              kp;
    pct_type              ti;
    pct_type              td;
  } st_type;

  st_type r;
  st_type n;

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  function automatic pct_type clip(input logic signed [63:0] v, input pct_type lo,
                                   input pct_type hi);
    if (v < 64'(lo)) return lo;
    if (v > 64'(hi)) return hi;
    return pct_type'(v);
  endfunction : clip

  function automatic pct_type mag(input pct_type v);
    return (v < 0) ? -v : v;
  endfunction : mag

  function automatic pct_type mix(input logic [31:0] a, input logic [31:0] b,
                                  input pct_type f);
    pct_type d;
    d = pct_type'(b) - pct_type'(a);
    return pct_type'(a) + ((d * f) >>> FRAC_SH);
  endfunction : mix

  pct_type     ain;
  pct_type     bin;
  pct_type     cin;
  pct_type     sp_tgt;
  pct_type     fb_raw;
  pct_type     e;
  pct_type     ae;
  pct_type     dterm;
  pct_type     frac;
  pct_type     q;
  pct_type     revlim;
  logic [31:0] ctl;
  logic        dir_rev;
  logic [1:0]  mode;
  logic [7:0]  idx;
  logic [32:0] dtry;

  assign ain  = 32'(analog_in_a);
  assign bin  = 32'(analog_in_b);
  assign cin  = 32'(analog_in_c);
  assign ctl  = r.cfg[REG_CTRL];
  assign mode = ctl[CTRL_MODE_LSB +: 2];
  assign idx  = 8'(paddr[APB_ADDR_W-1:2]);

  // setpoint target, out-of-range code falls back to the digital value
  always_comb begin
    unique case (ctl[CTRL_SP_LSB +: 3])
      SP_AN_A:  sp_tgt = ain;
      SP_AN_B:  sp_tgt = bin;
      SP_AN_C:  sp_tgt = cin;
      SP_PULSE: sp_tgt = 32'(fast_pulse_input);
      SP_COMM:  sp_tgt = 32'(comm_value);
      SP_MULTI: sp_tgt = 32'(multi_ref_value);
      default:  sp_tgt = pct_type'(r.cfg[REG_DIG_SP]);
    endcase
  end

  // feedback source, codes above eight read analog a
  always_comb begin
    unique case (ctl[CTRL_FB_LSB +: 4])
      FB_AN_B:    fb_raw = bin;
      FB_AN_C:    fb_raw = cin;
      FB_A_MINUS: fb_raw = ain - bin;
      FB_PULSE:   fb_raw = 32'(fast_pulse_input);
      FB_COMM:    fb_raw = 32'(comm_value);
      FB_A_PLUS:  fb_raw = ain + bin;
      FB_MAX_AB:  fb_raw = (mag(ain) > mag(bin)) ? mag(ain) : mag(bin);
      FB_MIN_AB:  fb_raw = (mag(ain) < mag(bin)) ? mag(ain) : mag(bin);
      default:    fb_raw = ain;
    endcase
  end

  // deviation sign follows direction, the pin inverts it
  assign dir_rev = ctl[CTRL_DIR_BIT] ^ r.inv_s[1];
  assign e       = dir_rev ? r.fbf - r.sp : r.sp - r.fbf;
  assign ae      = mag(e);

  // derivative on feedback only, avoids a kick on setpoint steps
  assign dterm = clip(64'(((dir_rev ? r.fbf - r.fbp : r.fbp - r.fbf) * r.td) >>> 1),
                      -pct_type'(r.cfg[REG_DLIMIT]),
                      pct_type'(r.cfg[REG_DLIMIT]));

  // quotient of the shared divider with its sign restored
  assign q      = r.dneg ? -pct_type'(r.dn[31:0]) : pct_type'(r.dn[31:0]);
  assign dtry   = {r.dr[31:0], r.dn[DIV_W-1]};
  assign revlim = (r.cfg[REG_REV_CUT] < r.cfg[REG_MAX_FREQ]) ?
                  pct_type'(r.cfg[REG_REV_CUT]) : pct_type'(r.cfg[REG_MAX_FREQ]);

  ////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    logic signed [DIV_W-1:0] num;
    logic [31:0]             den;
    logic [31:0]             v;
    pct_type                 x;
    pct_type                 lo;
    pct_type                 hi;
    pct_type                 step;
    num  = '0;
    den  = 32'h0000_0001;
    v    = pwdata;
    x    = '0;
    lo   = pct_type'(r.cfg[REG_SW_LOW]);
    hi   = pct_type'(r.cfg[REG_SW_HIGH]);
    step = '0;
    n    = r;

    // pin synchronisers
    n.inv_s  = {r.inv_s[0], dir_invert_pin};
    n.gsel_s = {r.gsel_s[0], gain_set_pin};

    // apb: no wait state, answer in the first access cycle
    n.pready  = psel & ~penable;
    n.pslverr = psel & ~penable & ((idx >= 8'(NREG)) | (paddr[1:0] != 2'h0));
    n.prdata  = 32'h0000_0000;
    if (psel && !penable && !n.pslverr) begin
      if (idx < 8'(NRW)) n.prdata = r.cfg[idx];
      else if (idx == 8'(REG_SP_MON)) n.prdata = r.spm;
      else if (idx == 8'(REG_FB_MON)) n.prdata = r.fbm;
      else if (idx == 8'(REG_FREQ_REF)) n.prdata = r.frq;
    end
    if (psel && penable && r.pready && pwrite && !r.pslverr && idx < 8'(NRW)) begin
      // writes are clamped to the legal span, the control word is masked, never rejected
      if (idx == 8'(REG_CTRL)) v = pwdata & CTRL_MASK;
      else if (pwdata > CFG_MAX[idx]) v = CFG_MAX[idx];
      if ((idx == 8'(REG_TI1) || idx == 8'(REG_TI2)) && v == 32'h0000_0000)
        v = 32'h0000_0001;
      if (idx == 8'(REG_SW_LOW) && v > r.cfg[REG_SW_HIGH])
        v = r.cfg[REG_SW_HIGH];
      if (idx == 8'(REG_SW_HIGH) && v < r.cfg[REG_SW_LOW])
        v = r.cfg[REG_SW_LOW];
      n.cfg[idx] = v;
    end

    // calculation period tick
    if (r.tick == '0) begin
      n.tick = TICK_W'(CALC_CYCLES_P - 1);
      if (r.phase == PH_IDLE) n.phase = PH_FBF;
    end else begin
      n.tick = r.tick - 1'b1;
    end

    // operands for the current step
    unique case (r.phase)
      PH_FBF: begin
        num = DIV_W'((fb_raw > FULL_SCALE ? FULL_SCALE : (fb_raw < 0 ? 0 : fb_raw))
              - r.fbf) * CALC_MS;
        den = r.cfg[REG_FB_FILT] * MS_PER_UNIT + CALC_MS;
      end
      PH_RAMP: begin
        num = DIV_W'(FULL_SCALE * CALC_MS);
        den = (r.cfg[REG_RAMP] == 32'h0000_0000) ? 32'h0000_0001 :
              r.cfg[REG_RAMP] * MS_PER_UNIT;
      end
      PH_FRAC: begin
        // running frequency relative to maximum stands in for deviation
        x = (mode == GSW_FREQ) ? mag(r.outf) : ae;
        den = (hi > lo) ? 32'(hi - lo) : 32'h0000_0001;
        if (x >= hi) num = DIV_W'(den) * FRAC_ONE;
        else if (x > lo) num = DIV_W'(x - lo) * FRAC_ONE;
      end
      PH_P: begin
        num = DIV_W'(r.kp * e);
        den = 32'(KP_SCALE);
      end
      PH_I: begin
        num = DIV_W'(e) * (CALC_MS << INT_SH);
        den = 32'(r.ti * MS_PER_UNIT);
      end
      PH_OFILT: begin
        num = DIV_W'(r.outu - r.outf) * CALC_MS;
        den = r.cfg[REG_OUT_FILT] * MS_PER_UNIT + CALC_MS;
      end
      PH_FREQ: begin
        num = DIV_W'(r.outf) * DIV_W'(r.cfg[REG_MAX_FREQ]);
        den = 32'(FULL_SCALE);
      end
      PH_SMON: begin
        num = DIV_W'(r.sp) * DIV_W'(r.cfg[REG_DISP_FS]);
        den = 32'(FULL_SCALE);
      end
      PH_FMON: begin
        num = DIV_W'(r.fbf) * DIV_W'(r.cfg[REG_DISP_FS]);
        den = 32'(FULL_SCALE);
      end
      default: begin
        num = '0;
        den = 32'h0000_0001;
      end
    endcase

    // one shared restoring divider, a bit per clock
    if (r.phase != PH_IDLE && !r.busy) begin
      if (r.phase == PH_FRAC && ae < pct_type'(r.cfg[REG_DEADBAND])) begin
        n.phase = PH_SMON;
      end else begin
        n.busy = 1'b1;
        n.cnt  = 6'(DIV_W);
        n.dneg = num < 0;
        n.dn   = (num < 0) ? DIV_W'(-num) : DIV_W'(num);
        n.dr   = '0;
        n.dd   = den;
      end
    end else if (r.busy && r.cnt != 6'h00) begin
      n.cnt = r.cnt - 6'h01;
      if (dtry >= {1'b0, r.dd}) begin
        n.dr = dtry - {1'b0, r.dd};
        n.dn = {r.dn[DIV_W-2:0], 1'b1};
      end else begin
        n.dr = dtry;
        n.dn = {r.dn[DIV_W-2:0], 1'b0};
      end
    end else if (r.busy) begin
      n.busy = 1'b0;
      unique case (r.phase)
        PH_FBF: begin
          n.fbp   = r.fbf;
          n.fbf   = r.fbf + q;
          n.phase = PH_RAMP;
        end
        PH_RAMP: begin
          step = (q < 1) ? 1 : q;
          x = clip(64'(sp_tgt), 0, FULL_SCALE);
          if (r.cfg[REG_RAMP] == 32'h0000_0000) n.sp = x;
          else if (x > r.sp) n.sp = (x - r.sp > step) ? r.sp + step : x;
          else n.sp = (r.sp - x > step) ? r.sp - step : x;
          n.phase = PH_FRAC;
        end
        PH_FRAC: begin
          unique case (mode)
            GSW_NONE: x = 0;
            GSW_PIN:  x = r.gsel_s[1] ? FRAC_ONE : 0;
            default:  x = q;
          endcase
          n.kp    = mix(r.cfg[REG_KP1], r.cfg[REG_KP2], x);
          n.ti    = mix(r.cfg[REG_TI1], r.cfg[REG_TI2], x);
          n.td    = mix(r.cfg[REG_TD1], r.cfg[REG_TD2], x);
          n.phase = PH_P;
        end
        PH_P: begin
          n.pterm = q;
          n.phase = PH_I;
        end
        PH_I: begin
          x = clip(64'(r.integ) + 64'(q), -(FULL_SCALE << INT_SH),
                   FULL_SCALE << INT_SH);
          n.integ = x;
          n.outu  = clip(64'(r.pterm) + 64'(x >>> INT_SH) + 64'(dterm),
                         -FULL_SCALE, FULL_SCALE);
          n.phase = PH_OFILT;
        end
        PH_OFILT: begin
          n.outf  = r.outf + q;
          n.phase = PH_FREQ;
        end
        PH_FREQ: begin
          n.frq   = (q < -revlim) ? -revlim : q;
          n.phase = PH_SMON;
        end
        PH_SMON: begin
          n.spm   = q;
          n.phase = PH_FMON;
        end
        default: begin
          n.fbm   = q;
          n.phase = PH_IDLE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r        <= '0;
      r.cfg    <= CFG_RST;
      r.sp     <= pct_type'(CFG_RST[REG_DIG_SP]);
      r.kp     <= pct_type'(CFG_RST[REG_KP1]);
      r.ti     <= pct_type'(CFG_RST[REG_TI1]);
      r.dd     <= 32'h0000_0001;
      r.phase  <= PH_IDLE;
    end else begin
      r <= n;
    end
  end

  // outputs straight from the state flops
  assign prdata           = r.prdata;
  assign pready           = r.pready;
  assign pslverr          = r.pslverr;
  assign freq_ref         = r.frq;
  assign setpoint_monitor = r.spm;
  assign feedback_monitor = r.fbm;

endmodule : process_pid_regulator

/* core/pid_pkg.sv */
// constants, register map and types for the process regulator
// assumes one 125 MHz clock and an apb master with 32-bit data
package pid_pkg;

  typedef logic signed [31:0] pct_type;  // 0.01 % units, 10000 is 100.00 %

  // register map, byte address is four times the index
  localparam int APB_ADDR_W    = 8;
  localparam int NRW           = 18;
  localparam int NREG          = 21;
  localparam int REG_CTRL      = 0;
  localparam int REG_DIG_SP    = 1;
  localparam int REG_DISP_FS   = 2;
  localparam int REG_KP1       = 3;
  localparam int REG_TI1       = 4;
  localparam int REG_TD1       = 5;
  localparam int REG_KP2       = 6;
  localparam int REG_TI2       = 7;
  localparam int REG_TD2       = 8;
  localparam int REG_REV_CUT   = 9;
  localparam int REG_DEADBAND  = 10;
  localparam int REG_DLIMIT    = 11;
  localparam int REG_RAMP      = 12;
  localparam int REG_FB_FILT   = 13;
  localparam int REG_OUT_FILT  = 14;
  localparam int REG_SW_LOW    = 15;
  localparam int REG_SW_HIGH   = 16;
  localparam int REG_MAX_FREQ  = 17;
  localparam int REG_SP_MON    = 18;
  localparam int REG_FB_MON    = 19;
  localparam int REG_FREQ_REF  = 20;

  // control word fields
  localparam int          CTRL_SP_LSB   = 0;
  localparam int          CTRL_FB_LSB   = 4;
  localparam int          CTRL_DIR_BIT  = 8;
  localparam int          CTRL_MODE_LSB = 12;
  localparam logic [31:0] CTRL_MASK     = 32'h0000_31FF;

  // reset values and write ceilings, index 17 first
  localparam logic [NRW-1:0][31:0] CFG_RST = '{
    32'h0000_1388, 32'h0000_1F40, 32'h0000_07D0, 32'h0000_0000, 32'h0000_0000,
    32'h0000_0000, 32'h0000_000A, 32'h0000_0000, 32'h0000_00C8, 32'h0000_0000,
    32'h0000_00C8, 32'h0000_00C8, 32'h0000_0000, 32'h0000_00C8, 32'h0000_00C8,
    32'h0000_03E8, 32'h0000_1388, 32'h0000_0000};
  localparam logic [NRW-1:0][31:0] CFG_MAX = '{
    32'h0000_FFFF, 32'h0000_2710, 32'h0000_2710, 32'h0000_1770, 32'h0000_1770,
    32'h0000_FDE8, 32'h0000_2710, 32'h0000_2710, 32'h0000_FFFF, 32'h0000_2710,
    32'h0000_03E8, 32'h0000_03E8, 32'h0000_2710, 32'h0000_03E8, 32'h0000_03E8,
    32'h0000_FFFF, 32'h0000_2710, 32'h0000_31FF};

  // fixed-point scales
  localparam int FULL_SCALE = 10000;
  localparam int KP_SCALE   = 1000;
  localparam int FRAC_ONE   = 1024;
  localparam int FRAC_SH    = 10;
  localparam int INT_SH     = 8;
  localparam int MS_PER_UNIT = 10;
  localparam int DIV_W      = 48;

  // calculation period
  localparam int CALC_PERIOD_NS = 2000000;
  localparam int CLK_PERIOD_NS  = 8;
  localparam int CALC_CYCLES    = CALC_PERIOD_NS / CLK_PERIOD_NS;
  localparam int CALC_MS        = CALC_PERIOD_NS / 1000000;

  // source and mode codes
  localparam logic [2:0] SP_DIGITAL = 3'h0;
  localparam logic [2:0] SP_AN_A    = 3'h1;
  localparam logic [2:0] SP_AN_B    = 3'h2;
  localparam logic [2:0] SP_AN_C    = 3'h3;
  localparam logic [2:0] SP_PULSE   = 3'h4;
  localparam logic [2:0] SP_COMM    = 3'h5;
  localparam logic [2:0] SP_MULTI   = 3'h6;
  localparam logic [3:0] FB_AN_A    = 4'h0;
  localparam logic [3:0] FB_AN_B    = 4'h1;
  localparam logic [3:0] FB_AN_C    = 4'h2;
  localparam logic [3:0] FB_A_MINUS = 4'h3;
  localparam logic [3:0] FB_PULSE   = 4'h4;
  localparam logic [3:0] FB_COMM    = 4'h5;
  localparam logic [3:0] FB_A_PLUS  = 4'h6;
  localparam logic [3:0] FB_MAX_AB  = 4'h7;
  localparam logic [3:0] FB_MIN_AB  = 4'h8;
  localparam logic [1:0] GSW_NONE   = 2'h0;
  localparam logic [1:0] GSW_PIN    = 2'h1;
  localparam logic [1:0] GSW_DEV    = 2'h2;
  localparam logic [1:0] GSW_FREQ   = 2'h3;

  typedef enum logic [3:0] {
    PH_IDLE  = 4'h0,
    PH_FBF   = 4'h1,
    PH_RAMP  = 4'h2,
    PH_FRAC  = 4'h3,
    PH_P     = 4'h4,
    PH_I     = 4'h5,
    PH_OFILT = 4'h6,
    PH_FREQ  = 4'h7,
    PH_SMON  = 4'h8,
    PH_FMON  = 4'h9
  } phase_type;

endpackage : pid_pkg

/* bench/pid_regulator_sva.sv */
// checker for the regulator: apb answer timing and output ranges
// assumes the bench leaves max frequency and reverse cutoff at defaults
module pid_regulator_checker
  import pid_pkg::*;
#(
  parameter int CALC_CYCLES_P = CALC_CYCLES
) (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire pct_type     freq_ref,
  input wire logic [31:0] setpoint_monitor,
  input wire logic [31:0] feedback_monitor
);
  localparam int FREQ_TOP  = 5000;
  localparam int REV_FLOOR = -200;
  localparam int MIN_GAP   = CALC_CYCLES_P - 100;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  ////////////////////////////////////////////////////////////////////////////
  // cycles since freq_ref last moved; parked high so the first update passes
  logic [31:0] gap_r;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) gap_r <= 32'hFFFF_FFFF;
    else if ($changed(freq_ref)) gap_r <= 32'h0;
    else if (gap_r != 32'hFFFF_FFFF) gap_r <= gap_r + 32'h1;
  end

  ////////////////////////////////////////////////////////////////////////////
  // bus phases
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_done;
    psel && penable && pready;
  endsequence

  property p_ready_answer;
    s_setup |=> s_done;
  endproperty
  a_ready_answer: assert property (p_ready_answer) else $error("no ready after setup");
  property p_ready_single;
    pready |=> !pready;
  endproperty
  a_ready_single: assert property (p_ready_single) else $error("ready held too long");
  property p_err_with_ready;
    pslverr |-> s_done;
  endproperty
  a_err_with_ready: assert property (p_err_with_ready) else $error("error outside access");
  property p_rdata_idle;
    !pready |-> prdata == 32'h0;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside access");
  property p_freq_top;
    freq_ref <= FREQ_TOP;
  endproperty
  a_freq_top: assert property (p_freq_top) else $error("output above max");
  property p_rev_floor;
    freq_ref >= REV_FLOOR;
  endproperty
  a_rev_floor: assert property (p_rev_floor) else $error("reverse beyond cutoff");
  property p_calc_gap;
    $changed(freq_ref) |-> gap_r >= MIN_GAP;
  endproperty
  a_calc_gap: assert property (p_calc_gap) else $error("output moved twice in a period");
  property p_mon_scale;
    setpoint_monitor <= 32'h0000_FFFF && feedback_monitor <= 32'h0000_FFFF;
  endproperty
  a_mon_scale: assert property (p_mon_scale) else $error("monitor beyond scale");
endmodule : pid_regulator_checker

/* bench/input_source_model.sv */
// far-side model: analog, pulse, comm and multi-reference values
// assumes the bench loads values through load(); outputs follow on pclk
module input_source_model
  import pid_pkg::*;
(
  input  wire logic          pclk,
  output logic signed [15:0] analog_in_a,
  output logic signed [15:0] analog_in_b,
  output logic signed [15:0] analog_in_c,
  output logic signed [15:0] fast_pulse_input,
  output logic signed [15:0] comm_value,
  output logic signed [15:0] multi_ref_value
);
  timeunit 1ns;
  timeprecision 1ps;
  logic signed [15:0] val_r [6];

  // converters settle at zero until told otherwise
  initial foreach (val_r[i]) val_r[i] = 16'sh0;

  // one new conversion result per call, landing on a clock edge
  task automatic load(input int k, input logic signed [15:0] v);
    @(posedge pclk);
    val_r[k] <= v;
  endtask : load

  assign analog_in_a      = val_r[0];
  assign analog_in_b      = val_r[1];
  assign analog_in_c      = val_r[2];
  assign fast_pulse_input = val_r[3];
  assign comm_value       = val_r[4];
  assign multi_ref_value  = val_r[5];
endmodule : input_source_model

/* bench/testbench.sv */
// top bench: apb tasks, source selection, direction, deadband, gain sets
// assumes a shortened calculation period of 600 cycles
module testbench
  import pid_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int CALC = 600;
  localparam logic [31:0] RST_V [18] = '{32'h0, 32'h1388, 32'h3E8, 32'hC8, 32'hC8, 32'h0,
    32'hC8, 32'hC8, 32'h0, 32'hC8, 32'h0, 32'hA, 32'h0, 32'h0, 32'h0, 32'h7D0, 32'h1F40,
    32'h1388};
  localparam logic [15:0] SRC_V [6] = '{16'h0BB8, 16'hFC18, 16'h09C4, 16'h0FA0, 16'h1770,
    16'h1B58};
  localparam logic [31:0] SP_EXP [7] = '{32'h2710, 32'hBB8, 32'h0, 32'h9C4, 32'hFA0,
    32'h1770, 32'h1B58};
  localparam logic [31:0] FB_EXP [9] = '{32'hBB8, 32'h0, 32'h9C4, 32'hFA0, 32'hFA0,
    32'h1770, 32'h7D0, 32'hBB8, 32'h3E8};

  logic                pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0]          paddr;
  logic [31:0]         pwdata, prdata, setpoint_monitor, feedback_monitor;
  logic signed [15:0]  analog_in_a, analog_in_b, analog_in_c;
  logic signed [15:0]  fast_pulse_input, comm_value, multi_ref_value;
  logic                dir_invert_pin, gain_set_pin;
  pct_type             freq_ref;
  int                  bad_count, n_checks;

  ////////////////////////////////////////////////////////////////////////////
  // free-running 125 MHz clock
  initial pclk = 1'b0;
  always #4 pclk = ~pclk;

  process_pid_regulator #(.CALC_CYCLES_P(CALC)) i_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .analog_in_a(analog_in_a), .analog_in_b(analog_in_b), .analog_in_c(analog_in_c),
    .fast_pulse_input(fast_pulse_input), .comm_value(comm_value),
    .multi_ref_value(multi_ref_value), .dir_invert_pin(dir_invert_pin),
    .gain_set_pin(gain_set_pin), .freq_ref(freq_ref), .setpoint_monitor(setpoint_monitor),
    .feedback_monitor(feedback_monitor));

  input_source_model i_src (
    .pclk(pclk), .analog_in_a(analog_in_a), .analog_in_b(analog_in_b),
    .analog_in_c(analog_in_c), .fast_pulse_input(fast_pulse_input),
    .comm_value(comm_value), .multi_ref_value(multi_ref_value));

  ////////////////////////////////////////////////////////////////////////////
  // one apb transfer; waits on pready, not on a fixed wait count
  task automatic apb(input logic wr, input logic [7:0] ad, input logic [31:0] wd,
                     output logic [31:0] rd, output logic er);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= ad;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 20) bad_count++;
  endtask : apb

  task automatic check_eq(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check_eq

  task automatic check_true(input logic c);
    check_eq({31'h0, c}, 32'h1);
  endtask : check_true

  task automatic wr(input logic [7:0] ad, input logic [31:0] d);
    logic [31:0] q;
    logic        e;
    apb(1'b1, ad, d, q, e);
  endtask : wr

  task automatic rd_chk(input logic [7:0] ad, input logic [31:0] exp);
    logic [31:0] q;
    logic        e;
    apb(1'b0, ad, 32'h0, q, e);
    check_eq(q, exp);
  endtask : rd_chk

  task automatic wait_calc;
    repeat (2 * CALC) @(posedge pclk);
  endtask : wait_calc

  // a second reset mid-run also clears the integral before direction tests
  task automatic do_reset;
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
  endtask : do_reset

  task automatic final_report;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : final_report

  ////////////////////////////////////////////////////////////////////////////
  // hang guard, roughly twice the expected run
  initial begin
    repeat (60000) @(posedge pclk);
    bad_count++;
    final_report();
  end

  // main sequence
  initial begin
    logic [31:0] q;
    logic        e;
    pct_type     f0;
    {psel, penable, pwrite, dir_invert_pin, gain_set_pin} = 5'h0;
    paddr = 8'h0;
    pwdata = 32'h0;
    presetn = 1'b0;
    bad_count = 0;
    n_checks = 0;
    do_reset();
    for (int i = 0; i < 18; i++) rd_chk(8'(4 * i), RST_V[i]);
    apb(1'b0, 8'h54, 32'h0, q, e);
    check_eq({31'h0, e}, 32'h1);
    check_eq(q, 32'h0);
    apb(1'b0, 8'h05, 32'h0, q, e);
    check_eq({31'h0, e}, 32'h1);
    check_eq(q, 32'h0);
    wr(8'h04, 32'h4E20);
    rd_chk(8'h04, 32'h2710);
    wr(8'h3C, 32'h2328);
    rd_chk(8'h3C, 32'h1F40);
    wr(8'h08, 32'h2710);
    for (int k = 0; k < 6; k++) i_src.load(k, SRC_V[k]);
    for (int s = 0; s < 7; s++) begin
      wr(8'h00, 32'(s));
      wait_calc();
      check_eq(setpoint_monitor, SP_EXP[s]);
    end
    for (int s = 0; s < 9; s++) begin
      wr(8'h00, 32'(s) << 4);
      wait_calc();
      check_eq(feedback_monitor, FB_EXP[s]);
    end
    wr(8'h08, 32'h7D0);
    wait_calc();
    check_eq(setpoint_monitor, 32'h7D0);
    check_eq(feedback_monitor, 32'hC8);
    rd_chk(8'h48, 32'h7D0);
    rd_chk(8'h4C, 32'hC8);
    do_reset();
    wr(8'h00, 32'h100);
    wait_calc();
    check_eq(freq_ref, 32'hFFFF_FF38);
    rd_chk(8'h50, 32'hFFFF_FF38);
    dir_invert_pin <= 1'b1;
    wait_calc();
    check_true(freq_ref > 0);
    wr(8'h28, 32'h2710);
    wait_calc();
    f0 = freq_ref;
    wait_calc();
    check_eq(freq_ref, f0);
    wr(8'h28, 32'h0);
    dir_invert_pin <= 1'b0;
    wr(8'h00, 32'h1000);
    wr(8'h0C, 32'h0);
    wr(8'h18, 32'h3E8);
    wr(8'h04, 32'h2710);
    i_src.load(0, 16'sh0);
    gain_set_pin <= 1'b1;
    wait_calc();
    check_eq(freq_ref, 32'h1388);
    gain_set_pin <= 1'b0;
    wait_calc();
    check_true(freq_ref < 1000);
    // deviation mode halfway between thresholds: half of set two's gain
    do_reset();
    wr(8'h00, 32'h2000);
    wr(8'h0C, 32'h0);
    wr(8'h18, 32'h3E8);
    wr(8'h10, 32'h3E8);
    wr(8'h1C, 32'h3E8);
    wait_calc();
    check_true(freq_ref > 1245 && freq_ref < 1260);
    // ten second ramp moves the setpoint two counts a period
    wr(8'h30, 32'h3E8);
    wr(8'h08, 32'h2710);
    wr(8'h04, 32'h2710);
    wait_calc();
    check_true(setpoint_monitor > 5000 && setpoint_monitor < 5010);
    final_report();
  end
endmodule : testbench

bind process_pid_regulator pid_regulator_checker #(.CALC_CYCLES_P(CALC_CYCLES_P)) i_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .freq_ref(freq_ref),
  .setpoint_monitor(setpoint_monitor), .feedback_monitor(feedback_monitor));
